// file: bit_timer.v
// Bit timing: quantum prescaler, sync/segment sequencing and resynchronization.
// Assumes rx_in is already synchronized to clk_in.
module bit_timer (
  // Clock and reset
  input  wire       clk_in,
  input  wire       nrst_in,
  // Control and line
  input  wire       run_in,
  input  wire       rx_in,
  input  wire       tx_in,
  // Timing fields, each stored as value minus one
  input  wire [5:0] presc_in,
  input  wire [3:0] seg1_in,
  input  wire [2:0] seg2_in,
  input  wire [1:0] sjw_in,
  // Bit events
  output reg        sample_out,
  output reg        bit_out,
  output reg        txpt_out
);
  localparam ST_SYNC = 2'd0;
  localparam ST_SEG1 = 2'd1;
  localparam ST_SEG2 = 2'd2;

  reg  [5:0] pre_q;
  reg  [1:0] st_q;
  reg  [4:0] cnt_q;
  reg  [4:0] len_q;
  reg        rx_q;
  reg        edge_seen_q;
  reg  [4:0] len_d;

  function [4:0] lesser;
    input [4:0] a;
    input [4:0] b;
    lesser = (a < b) ? a : b;
  endfunction

  wire       tq      = (pre_q == presc_in);
  wire [4:0] sjw     = {3'b000, sjw_in} + 5'd1;
  wire [4:0] elapsed = cnt_q + 5'd1;
  wire [4:0] remain  = len_q - cnt_q;
  wire       edge_ok = run_in & ~rx_q & rx_in & ~tx_in & ~edge_seen_q;

  always @* begin
    len_d = len_q;
    if (edge_ok && st_q == ST_SEG1) begin
      len_d = len_q + lesser(elapsed, sjw);
    end else if (edge_ok && st_q == ST_SEG2) begin
      len_d = len_q - lesser(remain, sjw);
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_q       <= 6'h00;
      st_q        <= ST_SYNC;
      cnt_q       <= 5'h00;
      len_q       <= 5'h01;
      rx_q        <= 1'b1;
      edge_seen_q <= 1'b0;
      sample_out  <= 1'b0;
      bit_out     <= 1'b1;
      txpt_out    <= 1'b0;
    end else begin
      sample_out <= 1'b0;
      txpt_out   <= 1'b0;
      rx_q       <= rx_in;
      if (!run_in) begin
        pre_q       <= 6'h00;
        st_q        <= ST_SYNC;
        cnt_q       <= 5'h00;
        len_q       <= 5'h01;
        edge_seen_q <= 1'b0;
      end else begin
        pre_q <= tq ? 6'h00 : pre_q + 6'h01;
        len_q <= len_d;
        if (edge_ok) begin
          edge_seen_q <= 1'b1;
        end
        if (tq) begin
          if (elapsed >= len_d) begin
            cnt_q <= 5'h00;
            case (st_q)
              ST_SYNC: begin
                st_q  <= ST_SEG1;
                len_q <= {1'b0, seg1_in} + 5'd1;
              end
              ST_SEG1: begin
                st_q       <= ST_SEG2;
                sample_out <= 1'b1;
                bit_out    <= rx_in;
                len_q      <= {2'b00, seg2_in} + 5'd1;
              end
              ST_SEG2: begin
                st_q        <= ST_SYNC;
                len_q       <= 5'h01;
                txpt_out    <= 1'b1;
                edge_seen_q <= 1'b0;
              end
              default: begin
                st_q  <= ST_SYNC;
                len_q <= 5'h01;
              end
            endcase
          end else begin
            cnt_q <= elapsed;
          end
        end
      end
    end
  end
endmodule // bit_timer

// file: can_consts.vh
// Constants for the CAN mailbox, error and bit-timing block.
// Assumes an 8-bit register port with byte addresses and one 200 MHz clock.
//
// Notes on behaviour
// - Each mailbox is 16 bytes: status, length, four ident, eight payload, two stamp.
// - Transmit mailbox writable only while empty; status byte at offset 0.
// - Received message shown in output mailbox until software releases it.
// - Hardware stores match index at offset 0 and 16-bit stamp at 14-15.
// - Hardware keeps readable transmit and receive error counters.
// - Transmit counter above 255 enters bus-off, sets flag, stops traffic.
// - Leaving bus-off needs 128 runs of 11 recessive bits.
// - With auto bus-off management, recovery starts on entering bus-off.
// - Receive line is not watched in initialization, so recovery needs normal.
// - Sync segment is exactly one quantum; edges expected there.
// - Segment one is 1 to 16 quanta, ends at sample point, may lengthen.
// - Segment two is 1 to 8 quanta, ends at transmit point, may shorten.
// - Jump width 1 to 4 quanta caps every lengthening or shortening.
// - Only first dominant-to-recessive edge per bit counts, not while sending recessive.
// - Edge in segment one lengthens it; edge in segment two shortens it.
// - Four interrupt outputs, each source enabled separately.
// - Transmit interrupt when any mailbox request-completed flag is set.
// - Receive FIFO interrupt on new message, full, or overrun.
// - Status interrupt on enabled error flag or start-of-frame while sleeping.
// - Timing, filter and diagnostic registers writable only in initialization.
// - Leaving initialization waits for 11 recessive bits, then clears acknowledge.
`ifndef CAN_CONSTS_VH
`define CAN_CONSTS_VH
`define A_CTRL      8'h00
`define A_STAT      8'h01
`define A_TXSTAT    8'h02
`define A_FIFO0     8'h03
`define A_FIFO1     8'h04
`define A_IEN       8'h05
`define A_ESTAT     8'h06
`define A_EIEN      8'h07
`define A_TEC       8'h08
`define A_REC       8'h09
`define A_BT0       8'h0a
`define A_BT1       8'h0b
`define A_FCFG      8'h0c
`define A_FMODE     8'h0d
`define A_DIAG      8'h0e
`define MB_TX0      4'h1
`define MB_RX0      4'h4
`define MB_RX1      4'h5
`define OFF_CS      4'h0
`define OFF_STAMP_L 4'he
`define OFF_STAMP_H 4'hf
`define CTRL_RESET  8'h01
`define BT1_RESET   8'h23
`define REC_BITS    4'd11
`define REC_SEQS    8'd128
`define FIFO_DEPTH  2'd3
`define WARN_LIMIT  9'd96
`define PASV_LIMIT  9'd128
`endif

// file: can_core_chk.sv
// Port checker for the mailbox core.
// Assumes one clock and the register map of the core.
module can_core_chk (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       nrst_in,
  // Register port and lines
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       tx_line_out,
  input wire logic       tx_bit_in,
  input wire logic [2:0] tx_req_out,
  input wire logic [2:0] tx_done_in,
  input wire logic       rxs_commit_in,
  input wire logic       rxs_fifo_in,
  input wire logic       irq_tx_out,
  input wire logic       irq_fifo0_out,
  input wire logic       irq_fifo1_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic [7:0] ien_q;
  // =========================================================
  // Shadow of the interrupt enable register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) ien_q <= 8'h00;
    else if (wr_in && addr_in == 8'h05) ien_q <= wdata_in;
  end
  sequence s_init_req;
    wr_in && addr_in == 8'h00 && wdata_in[0];
  endsequence
  sequence s_commit0;
    rxs_commit_in && !rxs_fifo_in && ien_q[1];
  endsequence
  property p_rdata_idle;
    !$past(rd_in) |-> rdata_out == 8'h00;
  endproperty
  property p_ien_read;
    rd_in && addr_in == 8'h05 |=> rdata_out == ien_q;
  endproperty
  property p_init_quiet;
    s_init_req |=> ##1 (tx_line_out && tx_req_out == 3'h0);
  endproperty
  property p_line_quiet;
    !tx_line_out |-> !tx_bit_in;
  endproperty
  property p_done_clears;
    tx_done_in[0] |=> !tx_req_out[0] [*2];
  endproperty
  property p_tx_irq;
    tx_done_in != 3'h0 && ien_q[0] |=> irq_tx_out;
  endproperty
  property p_tx_mask;
    !ien_q[0] |-> !irq_tx_out;
  endproperty
  property p_fifo0_irq;
    s_commit0 |=> irq_fifo0_out;
  endproperty
  property p_fifo0_mask;
    ien_q[3:1] == 3'h0 |-> !irq_fifo0_out;
  endproperty
  property p_fifo1_mask;
    ien_q[6:4] == 3'h0 |-> !irq_fifo1_out;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  a_ien_read: assert property (p_ien_read) else $error("enable readback wrong");
  a_init_quiet: assert property (p_init_quiet) else $error("traffic in init");
  a_line_quiet: assert property (p_line_quiet) else $error("line dominant unasked");
  a_done_clears: assert property (p_done_clears) else $error("request not cleared");
  a_tx_irq: assert property (p_tx_irq) else $error("tx irq missing");
  a_tx_mask: assert property (p_tx_mask) else $error("tx irq unmasked");
  a_fifo0_irq: assert property (p_fifo0_irq) else $error("fifo0 irq missing");
  a_fifo0_mask: assert property (p_fifo0_mask) else $error("fifo0 irq unmasked");
  a_fifo1_mask: assert property (p_fifo1_mask) else $error("fifo1 irq unmasked");
endmodule // can_core_chk
bind can_mailbox_core can_core_chk can_core_chk_inst (.clk_in(clk_in), .nrst_in(nrst_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .tx_line_out(tx_line_out), .tx_bit_in(tx_bit_in), .tx_req_out(tx_req_out),
  .tx_done_in(tx_done_in), .rxs_commit_in(rxs_commit_in), .rxs_fifo_in(rxs_fifo_in),
  .irq_tx_out(irq_tx_out), .irq_fifo0_out(irq_fifo0_out), .irq_fifo1_out(irq_fifo1_out));

// file: can_mailbox_core.v
// CAN mailboxes, error counters, bus-off recovery, modes and interrupts.
// Assumes a frame engine on the same clock feeds receive bytes and events.
`include "can_consts.vh"
module can_mailbox_core (
  // Clock and reset
  input  wire       clk_in,
  input  wire       nrst_in,
  // Register port
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  // CAN pins
  input  wire       rx_line_in,
  output wire       tx_line_out,
  // Frame engine, transmit side
  output wire [2:0] tx_req_out,
  input  wire [1:0] tx_sel_in,
  input  wire [3:0] tx_idx_in,
  output reg  [7:0] tx_byte_out,
  input  wire       tx_bit_in,
  input  wire [2:0] tx_done_in,
  input  wire [2:0] tx_ok_in,
  input  wire       tx_err_in,
  // Frame engine, receive side
  input  wire       rxs_we_in,
  input  wire [3:0] rxs_idx_in,
  input  wire [7:0] rxs_byte_in,
  input  wire       rxs_commit_in,
  input  wire       rxs_fifo_in,
  input  wire [7:0] rxs_match_in,
  input  wire       rx_err_in,
  // Bit timing events
  output wire       sample_out,
  output wire       rx_bit_out,
  // Interrupts
  output wire       irq_tx_out,
  output wire       irq_fifo0_out,
  output wire       irq_fifo1_out,
  output wire       irq_err_out
);
  reg  [7:0] tx_mem [0:47];
  reg  [7:0] rx_mem [0:127];
  reg  [7:0] stg    [0:15];
  reg  [7:0] ctl_q;
  reg        ack_q;
  reg        wake_q;
  reg        errf_q;
  reg  [2:0] req_q;
  reg  [2:0] rqcp_q;
  reg  [2:0] txok_q;
  reg  [1:0] cnt_q  [0:1];
  reg  [1:0] wp_q   [0:1];
  reg  [1:0] rp_q   [0:1];
  reg  [1:0] ovr_q;
  reg  [7:0] ien_q;
  reg  [7:0] eien_q;
  reg  [7:0] bt0_q;
  reg  [7:0] bt1_q;
  reg  [7:0] fcfg_q;
  reg  [7:0] fmode_q;
  reg  [7:0] diag_q;
  reg  [8:0] tec_q;
  reg  [7:0] rec_q;
  reg        bo_q;
  reg        arm_q;
  reg  [3:0] run_q;
  reg  [7:0] seq_q;
  reg  [15:0] stamp_q;
  reg  [2:0] est_q;
  reg        rx_s1_q;
  reg        rx_s2_q;
  reg        rx_s3_q;
  reg  [7:0] rd_d;
  integer    i, j;
  integer    f;

  wire       init_req = ctl_q[0];
  wire       sleep    = ctl_q[1];
  wire       auto_bo  = ctl_q[6];
  wire       smp;
  wire       bitv;
  wire [3:0] mb  = addr_in[7:4];
  wire [3:0] off = addr_in[3:0];
  wire       wr_tx = wr_in && mb >= `MB_TX0 && mb < `MB_RX0;
  wire [1:0] wr_sel = mb[1:0] - 2'd1;
  wire       quiet = ack_q | bo_q;
  wire       seq11 = smp && bitv && run_q == `REC_BITS - 4'd1;

  // Encoding of the FIFO control bytes, used only by the read path.
  function [7:0] fifo_byte;
    input [1:0] cnt;
    input       ovr;
    fifo_byte = {3'b000, ovr, (cnt == `FIFO_DEPTH), 1'b0, cnt};
  endfunction

  function [1:0] wrap;
    input [1:0] p;
    wrap = (p == `FIFO_DEPTH - 2'd1) ? 2'd0 : p + 2'd1;
  endfunction

  // ==========================================================
  // Receive pin synchronizer and bit timing
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_line_in;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  bit_timer u_bit_timer (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .run_in     (1'b1),
    .rx_in      (rx_s2_q),
    .tx_in      (tx_line_out),
    .presc_in   (bt0_q[5:0]),
    .seg1_in    (bt1_q[3:0]),
    .seg2_in    (bt1_q[6:4]),
    .sjw_in     (bt0_q[7:6]),
    .sample_out (smp),
    .bit_out    (bitv),
    .txpt_out   ()
  );

  assign sample_out  = smp;
  assign rx_bit_out  = bitv;
  assign tx_line_out = quiet ? 1'b1 : tx_bit_in;
  assign tx_req_out  = quiet ? 3'b000 : req_q;

  // ==========================================================
  // Modes, error counters and bus-off recovery
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctl_q   <= `CTRL_RESET;
      ack_q   <= 1'b1;
      tec_q   <= 9'h000;
      rec_q   <= 8'h00;
      bo_q    <= 1'b0;
      arm_q   <= 1'b0;
      run_q   <= 4'h0;
      seq_q   <= 8'h00;
      stamp_q <= 16'h0000;
    end else begin
      if (wr_in && addr_in == `A_CTRL) begin
        ctl_q <= wdata_in & 8'h43;
      end
      if (smp) begin
        stamp_q <= stamp_q + 16'h0001;
      end
      if (init_req || !smp) begin
        run_q <= init_req ? 4'h0 : run_q;
      end else if (!bitv || seq11) begin
        run_q <= 4'h0;
      end else begin
        run_q <= run_q + 4'h1;
      end
      if (init_req) begin
        ack_q <= 1'b1;
      end else if (ack_q && seq11) begin
        ack_q <= 1'b0;
      end
      if (!bo_q) begin
        if (tx_err_in) begin
          tec_q <= tec_q + 9'd8;
        end else if (|(tx_done_in & tx_ok_in) && tec_q != 9'h000) begin
          tec_q <= tec_q - 9'd1;
        end
        if (rx_err_in && rec_q != 8'hff) begin
          rec_q <= rec_q + 8'd1;
        end else if (rxs_commit_in && rec_q != 8'h00) begin
          rec_q <= rec_q - 8'd1;
        end
      end
      if (!bo_q && tec_q[8]) begin
        bo_q  <= 1'b1;
        arm_q <= auto_bo;
        seq_q <= 8'h00;
      end else if (bo_q) begin
        if (ack_q) begin
          arm_q <= 1'b1;
        end
        if (arm_q && !ack_q && seq11) begin
          if (seq_q == `REC_SEQS - 8'd1) begin
            bo_q  <= 1'b0;
            arm_q <= 1'b0;
            tec_q <= 9'h000;
            rec_q <= 8'h00;
          end else begin
            seq_q <= seq_q + 8'h01;
          end
        end
      end
    end
  end

  // ==========================================================
  // Protected and plain configuration registers
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ien_q   <= 8'h00;
      eien_q  <= 8'h00;
      bt0_q   <= 8'h00;
      bt1_q   <= `BT1_RESET;
      fcfg_q  <= 8'h00;
      fmode_q <= 8'h00;
      diag_q  <= 8'h00;
    end else if (wr_in) begin
      if (addr_in == `A_IEN) begin
        ien_q <= wdata_in;
      end
      if (addr_in == `A_EIEN) begin
        eien_q <= wdata_in;
      end
      if (ack_q) begin
        if (addr_in == `A_BT0) begin
          bt0_q <= wdata_in;
        end
        if (addr_in == `A_BT1) begin
          bt1_q <= wdata_in & 8'h7f;
        end
        if (addr_in == `A_FCFG) begin
          fcfg_q <= wdata_in;
        end
        if (addr_in == `A_FMODE) begin
          fmode_q <= wdata_in;
        end
        if (addr_in == `A_DIAG) begin
          diag_q <= wdata_in;
        end
      end
    end
  end

  // ==========================================================
  // Transmit mailboxes
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      req_q  <= 3'b000;
      rqcp_q <= 3'b000;
      txok_q <= 3'b000;
    end else begin
      for (i = 0; i < 3; i = i + 1) begin
        if (wr_in && addr_in == `A_TXSTAT && wdata_in[i]) begin
          rqcp_q[i] <= 1'b0;
          txok_q[i] <= 1'b0;
        end
        if (wr_tx && wr_sel == i && off == `OFF_CS && wdata_in[0] && !req_q[i]) begin
          req_q[i]  <= 1'b1;
          txok_q[i] <= 1'b0;
        end
        if (tx_done_in[i] && req_q[i]) begin
          req_q[i]  <= 1'b0;
          rqcp_q[i] <= 1'b1;
          txok_q[i] <= tx_ok_in[i];
        end
      end
    end
  end

  // Payload storage carries no reset; software fills it before use.
  always @(posedge clk_in) begin
    if (wr_tx && wr_sel != 2'd3 && off != `OFF_CS && !req_q[wr_sel]) begin
      tx_mem[{wr_sel, off}] <= wdata_in;
    end
    tx_byte_out <= tx_mem[{tx_sel_in, tx_idx_in}];
  end

  // ==========================================================
  // Receive FIFOs with output mailboxes
  always @(posedge clk_in) begin
    if (rxs_we_in) begin
      stg[rxs_idx_in] <= rxs_byte_in;
    end
    if (rxs_commit_in && !quiet && cnt_q[rxs_fifo_in] != `FIFO_DEPTH) begin
      for (j = 1; j < 14; j = j + 1) begin
        rx_mem[{rxs_fifo_in, wp_q[rxs_fifo_in], j[3:0]}] <= stg[j];
      end
      rx_mem[{rxs_fifo_in, wp_q[rxs_fifo_in], `OFF_CS}]      <= rxs_match_in;
      rx_mem[{rxs_fifo_in, wp_q[rxs_fifo_in], `OFF_STAMP_L}] <= stamp_q[7:0];
      rx_mem[{rxs_fifo_in, wp_q[rxs_fifo_in], `OFF_STAMP_H}] <= stamp_q[15:8];
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (f = 0; f < 2; f = f + 1) begin
        cnt_q[f] <= 2'd0;
        wp_q[f]  <= 2'd0;
        rp_q[f]  <= 2'd0;
      end
      ovr_q <= 2'b00;
    end else begin
      for (f = 0; f < 2; f = f + 1) begin : fifo_ctl
        reg push;
        reg pop;
        push = rxs_commit_in && !quiet && rxs_fifo_in == f && cnt_q[f] != `FIFO_DEPTH;
        pop  = wr_in && addr_in == `A_FIFO0 + f[7:0] && wdata_in[5] && cnt_q[f] != 2'd0;
        if (wr_in && addr_in == `A_FIFO0 + f[7:0] && wdata_in[4]) begin
          ovr_q[f] <= 1'b0;
        end
        if (rxs_commit_in && !quiet && rxs_fifo_in == f && cnt_q[f] == `FIFO_DEPTH) begin
          ovr_q[f] <= 1'b1;
        end
        if (push) begin
          wp_q[f] <= wrap(wp_q[f]);
        end
        if (pop) begin
          rp_q[f] <= wrap(rp_q[f]);
        end
        if (push && !pop) begin
          cnt_q[f] <= cnt_q[f] + 2'd1;
        end else if (pop && !push) begin
          cnt_q[f] <= cnt_q[f] - 2'd1;
        end
      end
    end
  end

  // ==========================================================
  // Error status and status-change flags
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      est_q  <= 3'b000;
      errf_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      est_q <= {bo_q, tec_q >= `PASV_LIMIT || rec_q >= 8'd128,
                tec_q >= `WARN_LIMIT || rec_q >= 8'd96};
      if (wr_in && addr_in == `A_STAT) begin
        if (wdata_in[2]) begin
          errf_q <= 1'b0;
        end
        if (wdata_in[3]) begin
          wake_q <= 1'b0;
        end
      end
      if (|({bo_q, tec_q >= `PASV_LIMIT || rec_q >= 8'd128,
             tec_q >= `WARN_LIMIT || rec_q >= 8'd96} & ~est_q & eien_q[2:0])) begin
        errf_q <= 1'b1;
      end
      if (sleep && rx_s3_q && !rx_s2_q) begin
        wake_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Interrupt outputs
  // four separately enabled vectors
  assign irq_tx_out    = ien_q[0] & (|rqcp_q);
  assign irq_fifo0_out = (ien_q[1] & cnt_q[0] != 2'd0) |
                         (ien_q[2] & cnt_q[0] == `FIFO_DEPTH) | (ien_q[3] & ovr_q[0]);
  assign irq_fifo1_out = (ien_q[4] & cnt_q[1] != 2'd0) |
                         (ien_q[5] & cnt_q[1] == `FIFO_DEPTH) | (ien_q[6] & ovr_q[1]);
  assign irq_err_out   = (ien_q[7] & errf_q) | (eien_q[7] & wake_q);

  // ==========================================================
  // Register read path, data valid the cycle after the strobe
  always @* begin
    rd_d = 8'h00;
    case (addr_in)
      `A_CTRL:   rd_d = ctl_q;
      `A_STAT:   rd_d = {4'h0, wake_q, errf_q, 1'b0, ack_q};
      `A_TXSTAT: rd_d = {1'b0, txok_q, 1'b0, rqcp_q};
      `A_FIFO0:  rd_d = fifo_byte(cnt_q[0], ovr_q[0]);
      `A_FIFO1:  rd_d = fifo_byte(cnt_q[1], ovr_q[1]);
      `A_IEN:    rd_d = ien_q;
      `A_ESTAT:  rd_d = {5'h00, est_q};
      `A_EIEN:   rd_d = eien_q;
      `A_TEC:    rd_d = tec_q[8] ? 8'hff : tec_q[7:0];
      `A_REC:    rd_d = rec_q;
      `A_BT0:    rd_d = bt0_q;
      `A_BT1:    rd_d = bt1_q;
      `A_FCFG:   rd_d = fcfg_q;
      `A_FMODE:  rd_d = fmode_q;
      `A_DIAG:   rd_d = diag_q;
      default: begin
        if (mb >= `MB_TX0 && mb < `MB_RX0) begin
          rd_d = (off == `OFF_CS) ? {5'h00, txok_q[mb[1:0] - 2'd1], ~req_q[mb[1:0] - 2'd1],
                                     req_q[mb[1:0] - 2'd1]} : tx_mem[{mb[1:0] - 2'd1, off}];
        end else if (mb == `MB_RX0 || mb == `MB_RX1) begin
          rd_d = rx_mem[{mb[0], rp_q[mb[0]], off}];
        end
      end
    endcase
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= rd_d;
    end else begin
      rdata_out <= 8'h00;
    end
  end
endmodule // can_mailbox_core

// file: can_node_model.sv
// Far-side node model: drives the receive line of the block.
// Assumes it shares the block clock; bit length is counted in clocks.
module can_node_model #(
  parameter int BIT_CLKS = 9
) (
  // Clock and control
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic active_in,
  // Bus line
  output logic      rx_line_out
);
  int   cnt_q;
  logic lvl_q;
  // =========================================================
  // Bit stream
  // idle recessive
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in || !active_in) begin
      cnt_q <= 0;
      lvl_q <= 1'b1;
    end else if (cnt_q == BIT_CLKS - 1) begin
      cnt_q <= 0;
      lvl_q <= ~lvl_q;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
  assign rx_line_out = lvl_q;
endmodule // can_node_model

// file: tb_top.sv
// Self-checking bench for the mailbox core with a far-side node model.
// Assumes a 200 MHz clock; timing left at prescale 1 so a bit is 8 clocks.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0, tx_bit_in = 1, tx_err_in = 0;
  logic rxs_we_in = 0, rxs_commit_in = 0, rxs_fifo_in = 0, rx_err_in = 0, node_active = 0;
  logic [7:0] addr_in = 0, wdata_in = 0, rxs_byte_in = 0, rxs_match_in = 0, rv, mb[16];
  logic [3:0] tx_idx_in = 0, rxs_idx_in = 0;
  logic [1:0] tx_sel_in = 0;
  logic [2:0] tx_done_in = 0, tx_ok_in = 0;
  wire  [7:0] rdata_out, tx_byte_out;
  wire  [2:0] tx_req_out;
  wire rx_line_in, tx_line_out, sample_out, rx_bit_out;
  wire irq_tx_out, irq_fifo0_out, irq_fifo1_out, irq_err_out;
  int failures = 0, checked = 0;
  logic [31:0] seed = 32'd90, base[4];
  always #2.5 clk_in = ~clk_in;
  can_node_model #(.BIT_CLKS(9)) can_node_model_inst (.clk_in(clk_in), .nrst_in(nrst_in),
    .active_in(node_active), .rx_line_out(rx_line_in));
  can_mailbox_core can_mailbox_core_inst (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .rx_line_in(rx_line_in), .tx_line_out(tx_line_out), .tx_req_out(tx_req_out),
    .tx_sel_in(tx_sel_in), .tx_idx_in(tx_idx_in), .tx_byte_out(tx_byte_out),
    .tx_bit_in(tx_bit_in), .tx_done_in(tx_done_in), .tx_ok_in(tx_ok_in), .tx_err_in(tx_err_in),
    .rxs_we_in(rxs_we_in), .rxs_idx_in(rxs_idx_in), .rxs_byte_in(rxs_byte_in),
    .rxs_commit_in(rxs_commit_in), .rxs_fifo_in(rxs_fifo_in), .rxs_match_in(rxs_match_in),
    .rx_err_in(rx_err_in), .sample_out(sample_out), .rx_bit_out(rx_bit_out),
    .irq_tx_out(irq_tx_out), .irq_fifo0_out(irq_fifo0_out), .irq_fifo1_out(irq_fifo1_out),
    .irq_err_out(irq_err_out));
  // =========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] msg_byte(input int k, input int i);
    return 8'(base[k] + i * 8'h1d);
  endfunction
  task automatic test_done();
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic wait_reg(input logic [7:0] a, m, v, input int bound);
    logic [7:0] r;
    int n = 0;
    do begin
      rd(a, r);
      n++;
    end while ((r & m) !== v && n < bound);
    chk(r & m, v);
    if ((r & m) !== v) test_done();
  endtask
  task automatic pulse_err(input int n, input logic rx);
    repeat (n) begin
      @(posedge clk_in);
      tx_err_in <= !rx;
      rx_err_in <= rx;
      @(posedge clk_in);
      tx_err_in <= 1'b0;
      rx_err_in <= 1'b0;
    end
  endtask
  // Gaps between sample pulses; resync may move each by the jump width only.
  task automatic measure(input int lo, input int hi, input logic need_move);
    int gap, moved;
    moved = 0;
    for (int k = 0; k < 24; k++) begin
      gap = 0;
      do begin
        @(posedge clk_in);
        #1 gap++;
      end while (sample_out !== 1'b1 && gap < 40);
      if (k > 1) chk({7'h0, gap >= lo && gap <= hi}, 8'h01);
      if (k > 1 && gap != 8) moved++;
    end
    chk({7'h0, moved > 0}, {7'h0, need_move});
  endtask
  task automatic push(input int k);
    for (int i = 1; i < 14; i++) begin
      @(posedge clk_in);
      rxs_we_in <= 1'b1;
      rxs_idx_in <= 4'(i);
      rxs_byte_in <= msg_byte(k, i);
    end
    @(posedge clk_in);
    rxs_we_in <= 1'b0;
    rxs_commit_in <= 1'b1;
    rxs_match_in <= 8'(8'h10 + k);
    @(posedge clk_in);
    rxs_commit_in <= 1'b0;
  endtask
  // =========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    rdchk(8'h01, 8'h01);
    rdchk(8'h0b, 8'h23);
    wr(8'h00, 8'h01);
    wr(8'h0a, 8'h00);
    rdchk(8'h0a, 8'h00);
    rv = 8'(rnd());
    wr(8'h0c, rv);
    rdchk(8'h0c, rv);
    wr(8'h00, 8'h00);
    rdchk(8'h01, 8'h01);
    wait_reg(8'h01, 8'h01, 8'h00, 100);
    wr(8'h0b, 8'h45);
    rdchk(8'h0b, 8'h23);
    rdchk(8'hff, 8'h00);
    node_active <= 1'b1;
    measure(8, 8, 1'b0);
    tx_bit_in <= 1'b0;
    measure(7, 9, 1'b1);
    tx_bit_in <= 1'b1;
    node_active <= 1'b0;
    for (int i = 1; i < 16; i++) begin
      mb[i] = 8'(rnd());
      wr({4'h1, 4'(i)}, mb[i]);
    end
    for (int i = 1; i < 16; i++) rdchk({4'h1, 4'(i)}, mb[i]);
    wr(8'h05, 8'h0f);
    wr(8'h10, 8'h01);
    #1 chk({5'h0, tx_req_out}, 8'h01);
    wr(8'h16, ~mb[6]);
    rdchk(8'h16, mb[6]);
    for (int i = 1; i < 14; i++) begin
      @(posedge clk_in);
      tx_sel_in <= 2'h0;
      tx_idx_in <= 4'(i);
      @(posedge clk_in);
      #1 chk(tx_byte_out, mb[i]);
    end
    @(posedge clk_in);
    tx_done_in <= 3'h1;
    tx_ok_in <= 3'h1;
    @(posedge clk_in);
    tx_done_in <= 3'h0;
    rdchk(8'h02, 8'h11);
    chk({7'h0, irq_tx_out}, 8'h01);
    wr(8'h02, 8'h01);
    #1 chk({7'h0, irq_tx_out}, 8'h00);
    pulse_err(3, 1'b1);
    rdchk(8'h09, 8'h03);
    for (int k = 0; k < 4; k++) base[k] = rnd();
    for (int k = 0; k < 3; k++) push(k);
    rdchk(8'h03, 8'h0b);
    push(3);
    rdchk(8'h03, 8'h1b);
    rdchk(8'h40, 8'h10);
    for (int i = 1; i < 14; i++) rdchk({4'h4, 4'(i)}, msg_byte(0, i));
    wr(8'h03, 8'h30);
    rdchk(8'h40, 8'h11);
    rdchk(8'h47, msg_byte(1, 7));
    wr(8'h20, 8'h01);
    wr(8'h07, 8'h04);
    wr(8'h05, 8'h80);
    wr(8'h00, 8'h40);
    pulse_err(31, 1'b0);
    rdchk(8'h08, 8'hf8);
    rdchk(8'h06, 8'h03);
    pulse_err(1, 1'b0);
    @(posedge clk_in) tx_bit_in <= 1'b0;
    rdchk(8'h06, 8'h07);
    rdchk(8'h08, 8'hff);
    chk({4'h0, tx_line_out, tx_req_out}, 8'h08);
    chk({7'h0, irq_err_out}, 8'h01);
    wr(8'h01, 8'h04);
    #1 chk({7'h0, irq_err_out}, 8'h00);
    repeat (5000) @(posedge clk_in);
    rdchk(8'h06, 8'h07);
    wait_reg(8'h06, 8'h04, 8'h00, 8000);
    rdchk(8'h08, 8'h00);
    wr(8'h00, 8'h00);
    pulse_err(32, 1'b0);
    repeat (12000) @(posedge clk_in);
    rdchk(8'h06, 8'h07);
    wr(8'h00, 8'h01);
    wr(8'h00, 8'h00);
    wait_reg(8'h06, 8'h04, 8'h00, 8000);
    test_done();
  end
endmodule // tb_top
